// File: bridge_pkg.sv
// Purpose: shared constants for the two-channel usb serial bridge
// Assumes: 50 MHz system clock, 8N1 framing on the ttl channel
// Notes: baud table index is what the host selects
`default_nettype none
package bridge_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int          BYTE_W        = 8;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          DIV_W         = 18;
  localparam int          SEL_W         = 4;
  localparam int          NUM_RATES     = 11;
  localparam int          FRAME_BITS    = 8;
  localparam int unsigned MIN_BAUD      = 300;
  localparam int unsigned MAX_BAUD      = 115200;
  localparam int unsigned BAUD_TABLE [0:NUM_RATES-1] =
    '{300, 600, 1200, 2400, 4800, 9600, 14400, 19200, 38400, 57600, 115200};
  localparam logic [SEL_W-1:0] BAUD_SEL_RESET = 4'h5;
  localparam logic        RTS_RESET     = 1'b0;
  localparam logic        DTR_RESET     = 1'b0;
  localparam logic        LINE_IDLE     = 1'b1;
  localparam logic        START_LEVEL   = 1'b0;
  localparam logic        STOP_LEVEL    = 1'b1;

  // clock cycles per bit, rounded to nearest
  function automatic logic [DIV_W-1:0] baud_div(input int unsigned clk_hz, input int unsigned baud);
    int unsigned q;
    q = (clk_hz + baud / 2) / baud;
    return q[DIV_W-1:0];
  endfunction : baud_div
endpackage : bridge_pkg
`default_nettype wire

// File: byte_fifo.sv
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: one clock, clock enable freezes all state
// Notes: depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             clk_en_in,
  // fill side
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  // drain side
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire full    = (count == (AW+1)'(DEPTH));
  wire empty   = (count == '0);
  wire push    = wr_valid_in && !full && clk_en_in;
  wire pop     = rd_ready_in && !empty && clk_en_in;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rd_ptr];

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// File: ttl_uart.sv
// Purpose: 8N1 serialiser and deserialiser with runtime bit divisor
// Assumes: divisor at least 2 cycles per bit
// Notes: rx line passes four flops before use
`timescale 1ns/1ps
`default_nettype none
module ttl_uart
  import bridge_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  // bit period in clocks
  input  wire logic [DIV_W-1:0]  div_in,
  // transmit byte stream
  input  wire logic [BYTE_W-1:0] tx_data_in,
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  // received byte stream, one-cycle strobe
  output logic      [BYTE_W-1:0] rx_data_out,
  output logic                   rx_valid_out,
  // serial lines
  output logic                   tx_line_out,
  input  wire logic              rx_line_in
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_START = 4'b0010,
    S_DATA  = 4'b0100,
    S_STOP  = 4'b1000
  } uart_state_t;

  uart_state_t      tx_state;
  logic [DIV_W-1:0] tx_cnt;
  logic [2:0]       tx_bit;
  logic [BYTE_W-1:0] tx_shift;

  uart_state_t      rx_state;
  logic [DIV_W-1:0] rx_cnt;
  logic [2:0]       rx_bit;
  logic [2:0]       rx_sync;
  logic             rx_level;

  wire [DIV_W-1:0] bit_last  = div_in - 1'b1;
  wire [DIV_W-1:0] half_last = (div_in >> 1) - 1'b1;
  wire             tx_tick   = (tx_cnt == '0);
  wire             rx_tick   = (rx_cnt == '0);

  assign tx_ready_out = (tx_state == S_IDLE);

  // transmitter
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_state    <= S_IDLE;
      tx_cnt      <= '0;
      tx_bit      <= '0;
      tx_shift    <= '0;
      tx_line_out <= LINE_IDLE;
    end else if (clk_en_in) begin
      tx_cnt <= tx_tick ? bit_last : tx_cnt - 1'b1;
      case (tx_state)
        S_IDLE: begin
          tx_line_out <= LINE_IDLE;
          if (tx_valid_in) begin
            tx_shift    <= tx_data_in;
            tx_cnt      <= bit_last;
            tx_line_out <= START_LEVEL;
            tx_state    <= S_START;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_line_out <= tx_shift[0];
            tx_shift    <= tx_shift >> 1;
            tx_bit      <= '0;
            tx_state    <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            if (tx_bit == 3'(FRAME_BITS-1)) begin
              tx_line_out <= STOP_LEVEL;
              tx_state    <= S_STOP;
            end else begin
              tx_line_out <= tx_shift[0];
              tx_shift    <= tx_shift >> 1;
              tx_bit      <= tx_bit + 1'b1;
            end
          end
        end
        default: begin
          if (tx_tick) begin
            tx_line_out <= LINE_IDLE;
            tx_state    <= S_IDLE;
          end
        end
      endcase
    end
  end

  // rx synchroniser, level moves once stages two and three agree
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rx_sync  <= {3{LINE_IDLE}};
      rx_level <= LINE_IDLE;
    end else if (clk_en_in) begin
      rx_sync <= {rx_sync[1:0], rx_line_in};
      if (rx_sync[1] == rx_sync[2]) rx_level <= rx_sync[2];
    end
  end

  // receiver, samples mid-bit
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rx_state     <= S_IDLE;
      rx_cnt       <= '0;
      rx_bit       <= '0;
      rx_data_out  <= '0;
      rx_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_valid_out <= 1'b0;
      rx_cnt       <= rx_tick ? bit_last : rx_cnt - 1'b1;
      case (rx_state)
        S_IDLE: begin
          if (rx_level == START_LEVEL) begin
            rx_cnt   <= half_last;
            rx_state <= S_START;
          end
        end
        S_START: begin
          if (rx_tick) begin
            rx_bit   <= '0;
            rx_state <= (rx_level == START_LEVEL) ? S_DATA : S_IDLE;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_data_out <= {rx_level, rx_data_out[BYTE_W-1:1]};
            rx_bit      <= rx_bit + 1'b1;
            if (rx_bit == 3'(FRAME_BITS-1)) rx_state <= S_STOP;
          end
        end
        default: begin
          if (rx_tick) begin
            rx_valid_out <= (rx_level == STOP_LEVEL);
            rx_state     <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ttl_uart
`default_nettype wire

// File: usb_serial_bridge_ports.sv
// Purpose: two-channel bridge between usb host and local destinations
// Assumes: usb endpoint logic presents byte streams with valid/ready
// Notes: comm channel is a plain byte pipe, ttl channel is 8N1
`timescale 1ns/1ps
`default_nettype none
module usb_serial_bridge_ports
  import bridge_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
  parameter int          DEPTH       = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  // host comm channel, host to main processor
  input  wire logic [BYTE_W-1:0] host_comm_data_in,
  input  wire logic              host_comm_valid_in,
  output logic                   host_comm_ready_out,
  // host comm channel, main processor to host
  output logic      [BYTE_W-1:0] host_comm_data_out,
  output logic                   host_comm_valid_out,
  input  wire logic              host_comm_ready_in,
  // host handshake line control
  input  wire logic              host_ctl_write_in,
  input  wire logic              host_rts_in,
  input  wire logic              host_dtr_in,
  // host ttl channel, host to tx line
  input  wire logic [BYTE_W-1:0] host_ttl_data_in,
  input  wire logic              host_ttl_valid_in,
  output logic                   host_ttl_ready_out,
  // host ttl channel, rx line to host
  output logic      [BYTE_W-1:0] host_ttl_data_out,
  output logic                   host_ttl_valid_out,
  input  wire logic              host_ttl_ready_in,
  // host ttl baud selection
  input  wire logic              host_baud_write_in,
  input  wire logic [SEL_W-1:0]  host_baud_sel_in,
  output logic      [SEL_W-1:0]  baud_sel_out,
  // main processor byte streams
  output logic      [BYTE_W-1:0] mcu_rx_data_out,
  output logic                   mcu_rx_valid_out,
  input  wire logic              mcu_rx_ready_in,
  input  wire logic [BYTE_W-1:0] mcu_tx_data_in,
  input  wire logic              mcu_tx_valid_in,
  output logic                   mcu_tx_ready_out,
  // main processor handshake line states
  output logic                   mcu_rts_out,
  output logic                   mcu_dtr_out,
  // ttl serial pins
  output logic                   ttl_tx_out,
  input  wire logic              ttl_rx_in,
  // ttl receive overflow, one-cycle strobe
  output logic                   ttl_rx_drop_out
);
  logic [SEL_W-1:0]  baud_sel;
  logic [DIV_W-1:0]  bit_div;
  logic [BYTE_W-1:0] tx_fifo_data;
  logic              tx_fifo_valid;
  logic              uart_tx_ready;
  logic [BYTE_W-1:0] rx_byte;
  logic              rx_strobe;
  logic              rx_fifo_ready;

  // only listed rates are accepted
  wire sel_ok  = (host_baud_sel_in < SEL_W'(NUM_RATES));
  wire sel_upd = host_baud_write_in && sel_ok;
  wire [DIV_W-1:0] next_bit_div = baud_div(CLK_FREQ_HZ, BAUD_TABLE[baud_sel]);

  assign baud_sel_out = baud_sel;

  // comm channel has no baud timing; fifos run at clock rate
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_comm_down (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .wr_data_in   (host_comm_data_in),
    .wr_valid_in  (host_comm_valid_in),
    .wr_ready_out (host_comm_ready_out),
    .rd_data_out  (mcu_rx_data_out),
    .rd_valid_out (mcu_rx_valid_out),
    .rd_ready_in  (mcu_rx_ready_in)
  );

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_comm_up (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .wr_data_in   (mcu_tx_data_in),
    .wr_valid_in  (mcu_tx_valid_in),
    .wr_ready_out (mcu_tx_ready_out),
    .rd_data_out  (host_comm_data_out),
    .rd_valid_out (host_comm_valid_out),
    .rd_ready_in  (host_comm_ready_in)
  );

  // handshake line states held for the main processor
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mcu_rts_out <= RTS_RESET;
      mcu_dtr_out <= DTR_RESET;
    end else if (clk_en_in && host_ctl_write_in) begin
      mcu_rts_out <= host_rts_in;
      mcu_dtr_out <= host_dtr_in;
    end
  end

  // ttl baud selection and registered bit period
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      baud_sel <= BAUD_SEL_RESET;
      bit_div  <= baud_div(CLK_FREQ_HZ, BAUD_TABLE[BAUD_SEL_RESET]);
    end else if (clk_en_in) begin
      if (sel_upd) baud_sel <= host_baud_sel_in;
      bit_div <= next_bit_div;
    end
  end

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_ttl_down (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .wr_data_in   (host_ttl_data_in),
    .wr_valid_in  (host_ttl_valid_in),
    .wr_ready_out (host_ttl_ready_out),
    .rd_data_out  (tx_fifo_data),
    .rd_valid_out (tx_fifo_valid),
    .rd_ready_in  (uart_tx_ready)
  );

  ttl_uart u_uart (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .div_in       (bit_div),
    .tx_data_in   (tx_fifo_data),
    .tx_valid_in  (tx_fifo_valid),
    .tx_ready_out (uart_tx_ready),
    .rx_data_out  (rx_byte),
    .rx_valid_out (rx_strobe),
    .tx_line_out  (ttl_tx_out),
    .rx_line_in   (ttl_rx_in)
  );

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_ttl_up (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .wr_data_in   (rx_byte),
    .wr_valid_in  (rx_strobe),
    .wr_ready_out (rx_fifo_ready),
    .rd_data_out  (host_ttl_data_out),
    .rd_valid_out (host_ttl_valid_out),
    .rd_ready_in  (host_ttl_ready_in)
  );

  // a line byte arriving to a full buffer is lost, flagged here
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ttl_rx_drop_out <= 1'b0;
    end else if (clk_en_in) begin
      ttl_rx_drop_out <= rx_strobe && !rx_fifo_ready;
    end
  end
endmodule : usb_serial_bridge_ports
`default_nettype wire

// File: usb_serial_bridge_ports_assertions.sv
// Purpose: port-level checks for the usb serial bridge
// Assumes: sim bit divisor of at least 8 clocks
// Notes: bound to the top module from the bench
`timescale 1ns/1ps
`default_nettype none
module bridge_checker
  import bridge_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
  parameter int          DEPTH       = FIFO_DEPTH
) (
  // clock and reset
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  input wire logic              clk_en_in,
  // comm streams
  input wire logic [BYTE_W-1:0] host_comm_data_in,
  input wire logic              host_comm_valid_in,
  input wire logic              host_comm_ready_out,
  input wire logic [BYTE_W-1:0] mcu_rx_data_out,
  input wire logic              mcu_rx_valid_out,
  input wire logic [BYTE_W-1:0] host_comm_data_out,
  input wire logic              host_comm_valid_out,
  input wire logic              host_comm_ready_in,
  // control
  input wire logic              host_ctl_write_in,
  input wire logic              host_rts_in,
  input wire logic              host_dtr_in,
  input wire logic              mcu_rts_out,
  input wire logic              mcu_dtr_out,
  input wire logic              host_baud_write_in,
  input wire logic [SEL_W-1:0]  host_baud_sel_in,
  input wire logic [SEL_W-1:0]  baud_sel_out,
  // serial out
  input wire logic              ttl_tx_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_start_bit;
    !ttl_tx_out [*8];
  endsequence
  sequence s_ctl_take;
    host_ctl_write_in && clk_en_in;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) rst_in |=>
    !mcu_rts_out && !mcu_dtr_out && ttl_tx_out && baud_sel_out == BAUD_SEL_RESET) else $error("reset state wrong");
  a_ctl_load: assert property (s_ctl_take |=>
    mcu_rts_out == $past(host_rts_in) && mcu_dtr_out == $past(host_dtr_in)) else $error("rts dtr not loaded");
  a_ctl_hold: assert property (!(host_ctl_write_in && clk_en_in) |=>
    $stable(mcu_rts_out) && $stable(mcu_dtr_out)) else $error("rts dtr changed");
  a_baud_load: assert property (host_baud_write_in && clk_en_in && host_baud_sel_in < NUM_RATES |=>
    baud_sel_out == $past(host_baud_sel_in)) else $error("baud index not loaded");
  a_baud_refuse: assert property (host_baud_write_in && host_baud_sel_in >= NUM_RATES |=>
    $stable(baud_sel_out)) else $error("bad baud index taken");
  a_comm_down: assert property (host_comm_valid_in && host_comm_ready_out && clk_en_in && !mcu_rx_valid_out |=>
    mcu_rx_valid_out && mcu_rx_data_out == $past(host_comm_data_in)) else $error("comm byte not passed");
  a_up_hold: assert property (host_comm_valid_out && !host_comm_ready_in && clk_en_in |=>
    host_comm_valid_out && $stable(host_comm_data_out)) else $error("host byte lost");
  a_start_bit: assert property ($fell(ttl_tx_out) |-> s_start_bit)
    else $error("start bit too short");
endmodule : bridge_checker
`default_nettype wire

// File: ttl_peer.sv
// Purpose: serial device on the far side of the ttl pins
// Assumes: bit time given in clocks by the caller
// Notes: line rests high between frames
`timescale 1ns/1ps
`default_nettype none
module ttl_peer (
  // clock
  input  wire logic clk_sys_in,
  // serial lines
  input  wire logic line_in,
  output var logic  line_out
);
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] b, input int div);
    line_out = 1'b0;
    repeat (div) @(negedge clk_sys_in);
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      repeat (div) @(negedge clk_sys_in);
    end
    line_out = 1'b1;
    repeat (div) @(negedge clk_sys_in);
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, output logic ok, input int div);
    @(negedge line_in);
    repeat (div / 2) @(negedge clk_sys_in);
    ok = !line_in;
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge clk_sys_in);
      b[i] = line_in;
    end
    repeat (div) @(negedge clk_sys_in);
    ok = ok && line_in;
  endtask : recv_byte
endmodule : ttl_peer
`default_nettype wire

// File: usb_serial_bridge_ports_tb.sv
// Purpose: self-checking bench for the usb serial bridge
// Assumes: clock scaled so 115200 bps is 10 clocks a bit
// Notes: inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none
module usb_serial_bridge_ports_tb;
  import bridge_pkg::*;
  localparam int unsigned SIM_HZ = 1_150_000;
  localparam int          LIMIT  = 20000;
  logic       clk_sys_in = 0, rst_in = 1, clk_en_in = 1;
  logic [7:0] host_comm_data_in = 0, mcu_tx_data_in = 0, host_ttl_data_in = 0;
  logic       host_comm_valid_in = 0, host_comm_ready_in = 0, mcu_tx_valid_in = 0, mcu_rx_ready_in = 0;
  logic       host_ctl_write_in = 0, host_rts_in = 0, host_dtr_in = 0;
  logic       host_ttl_valid_in = 0, host_ttl_ready_in = 0, host_baud_write_in = 0;
  logic [3:0] host_baud_sel_in = 0, baud_sel_out;
  logic [7:0] host_comm_data_out, host_ttl_data_out, mcu_rx_data_out;
  logic       host_comm_ready_out, host_comm_valid_out, host_ttl_ready_out, host_ttl_valid_out;
  logic       mcu_rx_valid_out, mcu_tx_ready_out, mcu_rts_out, mcu_dtr_out, ttl_tx_out, ttl_rx_drop_out;
  wire logic  ttl_rx_in;
  int         fails = 0, checks_done = 0, cyc = 0;
  usb_serial_bridge_ports #(.CLK_FREQ_HZ(SIM_HZ)) dut_u (.clk_sys_in, .rst_in, .clk_en_in,
    .host_comm_data_in, .host_comm_valid_in, .host_comm_ready_out, .host_comm_data_out,
    .host_comm_valid_out, .host_comm_ready_in, .host_ctl_write_in, .host_rts_in, .host_dtr_in,
    .host_ttl_data_in, .host_ttl_valid_in, .host_ttl_ready_out, .host_ttl_data_out, .host_ttl_valid_out,
    .host_ttl_ready_in, .host_baud_write_in, .host_baud_sel_in, .baud_sel_out, .mcu_rx_data_out,
    .mcu_rx_valid_out, .mcu_rx_ready_in, .mcu_tx_data_in, .mcu_tx_valid_in, .mcu_tx_ready_out,
    .mcu_rts_out, .mcu_dtr_out, .ttl_tx_out, .ttl_rx_in, .ttl_rx_drop_out);
  ttl_peer peer_u (.clk_sys_in, .line_in(ttl_tx_out), .line_out(ttl_rx_in));
  always #10 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      final_report();
    end
  end
  // idle state after reset
  task automatic t_reset();
    chk("lines", 8'h06, {3'h0, mcu_rts_out, mcu_dtr_out, ttl_tx_out, host_comm_ready_out, mcu_rx_valid_out});
    chk("baud_rst", {4'h0, BAUD_SEL_RESET}, {4'h0, baud_sel_out});
    chk("streams_rst", 8'h18, {3'h0, host_ttl_ready_out, mcu_tx_ready_out, host_ttl_valid_out, host_comm_valid_out,
      ttl_rx_drop_out});
  endtask : t_reset
  // clock enable low freezes taking and loading
  task automatic t_freeze();
    clk_en_in = 0;
    host_comm_data_in = 8'h77;
    host_comm_valid_in = 1;
    host_ctl_write_in = 1;
    repeat (2) @(negedge clk_sys_in);
    chk("freeze", 8'h03, {5'h0, mcu_rx_valid_out, mcu_dtr_out, mcu_rts_out});
    clk_en_in = 1;
    host_comm_valid_in = 0;
    host_ctl_write_in = 0;
    @(negedge clk_sys_in);
    chk("thaw", 8'h00, {7'h0, mcu_rx_valid_out});
  endtask : t_freeze
  // each rts/dtr pair, then held
  task automatic t_handshake();
    for (int k = 0; k < 4; k++) begin
      host_rts_in = k[0];
      host_dtr_in = k[1];
      host_ctl_write_in = 1;
      @(negedge clk_sys_in);
      host_ctl_write_in = 0;
      host_rts_in = ~k[0];
      host_dtr_in = ~k[1];
      @(negedge clk_sys_in);
      chk("rts_dtr", 8'(k), {6'h0, mcu_dtr_out, mcu_rts_out});
    end
  endtask : t_handshake
  // fill to refusal, drain back to back
  task automatic t_comm_down();
    host_comm_valid_in = 1;
    for (int i = 0; i < 17; i++) begin
      host_comm_data_in = 8'(8'h40 + i);
      @(negedge clk_sys_in);
    end
    chk("full", 8'h00, {7'h0, host_comm_ready_out});
    host_comm_valid_in = 0;
    mcu_rx_ready_in = 1;
    for (int i = 0; i < 16; i++) begin
      chk("down", 8'(8'h40 + i), mcu_rx_valid_out ? mcu_rx_data_out : 8'hxx);
      @(negedge clk_sys_in);
    end
    chk("down_empty", 8'h00, {7'h0, mcu_rx_valid_out});
  endtask : t_comm_down
  // host stalls, then drains
  task automatic t_comm_up();
    mcu_tx_valid_in = 1;
    for (int i = 0; i < 4; i++) begin
      mcu_tx_data_in = 8'(8'h90 + i);
      @(negedge clk_sys_in);
    end
    mcu_tx_valid_in = 0;
    repeat (3) @(negedge clk_sys_in);
    host_comm_ready_in = 1;
    for (int i = 0; i < 4; i++) begin
      chk("up", 8'(8'h90 + i), host_comm_valid_out ? host_comm_data_out : 8'hxx);
      @(negedge clk_sys_in);
    end
    chk("up_empty", 8'h00, {7'h0, host_comm_valid_out});
  endtask : t_comm_up
  task automatic set_baud(input logic [3:0] s, input logic [3:0] exp);
    host_baud_sel_in = s;
    host_baud_write_in = 1;
    @(negedge clk_sys_in);
    host_baud_write_in = 0;
    @(negedge clk_sys_in);
    chk("baud", {4'h0, exp}, {4'h0, baud_sel_out});
  endtask : set_baud
  // ttl byte out and back at one rate
  task automatic t_ttl(input logic [3:0] s, input logic [7:0] tb_b, input logic [7:0] rb);
    int         div;
    logic [7:0] got;
    logic       ok;
    set_baud(s, s);
    div = int'((SIM_HZ + BAUD_TABLE[s] / 2) / BAUD_TABLE[s]);
    fork
      peer_u.recv_byte(got, ok, div);
      begin
        host_ttl_data_in = tb_b;
        host_ttl_valid_in = 1;
        @(negedge clk_sys_in);
        host_ttl_valid_in = 0;
      end
    join
    chk("tx_byte", tb_b, got);
    chk("tx_frame", 8'h01, {7'h0, ok});
    peer_u.send_byte(rb, div);
    for (int n = 0; n < 4 * div && !host_ttl_valid_out; n++) @(negedge clk_sys_in);
    chk("rx_byte", rb, host_ttl_valid_out ? host_ttl_data_out : 8'hxx);
    host_ttl_ready_in = 1;
    @(negedge clk_sys_in);
    host_ttl_ready_in = 0;
  endtask : t_ttl
  // overrun the line buffer, seventeenth byte is dropped
  task automatic t_rx_drop();
    int div;
    set_baud(4'ha, 4'ha);
    div = int'((SIM_HZ + BAUD_TABLE[10] / 2) / BAUD_TABLE[10]);
    for (int i = 0; i < 17; i++) peer_u.send_byte(8'(8'h20 + i), div);
    for (int n = 0; n < div && !ttl_rx_drop_out; n++) @(negedge clk_sys_in);
    chk("rx_drop", 8'h01, {7'h0, ttl_rx_drop_out});
    host_ttl_ready_in = 1;
    for (int i = 0; i < 16; i++) begin
      chk("rx_keep", 8'(8'h20 + i), host_ttl_valid_out ? host_ttl_data_out : 8'hxx);
      @(negedge clk_sys_in);
    end
    host_ttl_ready_in = 0;
    chk("rx_empty", 8'h00, {7'h0, host_ttl_valid_out, ttl_rx_drop_out});
  endtask : t_rx_drop
  initial begin
    repeat (10) @(negedge clk_sys_in);
    rst_in = 0;
    @(negedge clk_sys_in);
    t_reset();
    t_handshake();
    t_comm_down();
    t_comm_up();
    t_freeze();
    set_baud(4'hb, 4'h5);
    set_baud(4'h0, 4'h0);
    t_ttl(4'ha, 8'ha5, 8'h5a);
    t_ttl(4'h9, 8'h3c, 8'hc3);
    t_rx_drop();
    final_report();
  end
endmodule : usb_serial_bridge_ports_tb
bind usb_serial_bridge_ports bridge_checker #(.CLK_FREQ_HZ(CLK_FREQ_HZ), .DEPTH(DEPTH)) chk_u (.clk_sys_in,
  .rst_in, .clk_en_in, .host_comm_data_in, .host_comm_valid_in, .host_comm_ready_out, .mcu_rx_data_out,
  .mcu_rx_valid_out, .host_comm_data_out, .host_comm_valid_out, .host_comm_ready_in, .host_ctl_write_in,
  .host_rts_in, .host_dtr_in, .mcu_rts_out, .mcu_dtr_out, .host_baud_write_in, .host_baud_sel_in,
  .baud_sel_out, .ttl_tx_out);
`default_nettype wire
